// file: inc/usp_pkg.sv
`default_nettype none
package usp_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] USP_OFS_STATUS  = 8'hc0;
  localparam logic [7:0] USP_OFS_CTRL_B  = 8'hc1;
  localparam logic [7:0] USP_OFS_CTRL_C  = 8'hc2;
  localparam logic [7:0] USP_OFS_BAUD_LO = 8'hc4;
  localparam logic [7:0] USP_OFS_BAUD_HI = 8'hc5;
  localparam logic [7:0] USP_OFS_DATA    = 8'hc6;
  localparam logic [7:0] USP_OFS_EVENT   = 8'hc7;
  localparam logic [7:0] USP_OFS_MASK    = 8'hc8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  USP_RST_CTRL_B = 8'h00;
  localparam logic [7:0]  USP_RST_CTRL_C = 8'h06;
  localparam logic [11:0] USP_RST_BAUD   = 12'h000;
  localparam logic [2:0]  USP_RST_EVENT  = 3'h0;
  localparam logic [2:0]  USP_RST_MASK   = 3'h0;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int USP_B_RXEN    = 4;
  localparam int USP_B_TXEN    = 3;
  localparam int USP_ST_RXC    = 7;
  localparam int USP_ST_TXC    = 6;
  localparam int USP_ST_UDRE   = 5;
  localparam int USP_EV_RXC    = 2;
  localparam int USP_EV_TXC    = 1;
  localparam int USP_EV_UDRE   = 0;
  localparam int USP_BAUD_HI_W = 4;

  localparam logic [1:0] USP_MODE_SPI   = 2'h3;
  localparam logic [3:0] USP_LAST_EDGE  = 4'hf;
  localparam logic [3:0] USP_FIRST_EDGE = 4'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] parity;
    logic       stop;
    logic       lsb_first;
    logic       cpha;
    logic       cpol;
  } usp_ctrl_c_s;

  typedef struct packed {
    logic lsb_first;
    logic cpha;
    logic cpol;
  } usp_frame_s;

endpackage
`default_nettype wire

// file: verilog/usp_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module usp_pin_sync
  import usp_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_async,
  output var  logic o_level
);

  logic s1;
  logic s2;
  logic s3;

  // ****************************************************************
  // Three stages; level moves only when the last two agree
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_level <= 1'b1;
    end else if (s2 == s3) begin
      o_level <= s3;
    end
  end

endmodule
`default_nettype wire

// file: verilog/usp_baud_gen.sv
`timescale 1ns/10ps
`default_nettype none
module usp_baud_gen
  import usp_pkg::*;
#(
  parameter int W = 12
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  input  wire logic         i_run,
  input  wire logic         i_reload,
  input  wire logic [W-1:0] i_divisor,
  output var  logic         o_tick
);

  logic [W-1:0] count;

  if (W < 2 || W > 16) begin : g_bad_width
    $error("usp_baud_gen: width out of range");
  end

  // ****************************************************************
  // One tick per half serial clock, every divisor+1 cycles
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count  <= '0;
      o_tick <= 1'b0;
    end else if (i_reload || !i_run) begin
      // Held at the divisor so a frame always starts with a full half
      count  <= i_divisor;
      o_tick <= 1'b0;
    end else if (count == '0) begin
      count  <= i_divisor;
      o_tick <= 1'b1;
    end else begin
      count  <= count - 1'b1;
      o_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: verilog/usp_spi_master.sv
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module usp_spi_master
  import usp_pkg::*;
#(
  parameter int DIV_W = 12
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output var  logic [7:0] o_rdata,
  output var  logic       o_irq,
  input  wire logic       i_miso,
  output var  logic       o_sclk,
  output var  logic       o_sclk_oe,
  output var  logic       o_mosi,
  output var  logic       o_mosi_oe
);

  typedef enum logic {ST_IDLE, ST_SHIFT} usp_state_e;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  usp_state_e       state;
  usp_ctrl_c_s      ctrl_c;
  usp_frame_s       frame;
  logic [7:0]       ctrl_b;
  logic [DIV_W-1:0] divider;
  logic [2:0]       events;
  logic [2:0]       mask;
  logic [7:0]       tx_buf;
  logic             tx_buf_valid;
  logic [7:0]       tx_shift;
  logic [7:0]       rx_shift;
  logic [7:0]       rx_buf;
  logic             rx_buf_valid;
  logic [3:0]       edge_cnt;
  logic             tick;
  logic             miso_level;
  logic             spi_mode;
  logic             tx_en;
  logic             rx_en;
  logic             wr_data;
  logic             rd_data;
  logic             leading;
  logic             sample_edge;
  logic             setup_edge;
  logic             frame_done;
  logic             load;
  logic [7:0]       next_rx;
  logic [7:0]       next_tx;
  logic [2:0]       ev_set;
  logic [2:0]       ev_clr;

  if (DIV_W != 12) begin : g_bad_div
    $error("usp_spi_master: divider must be 12 bits wide");
  end

  // Picks the wire bit for the chosen bit order
  function automatic logic usp_pick(input logic [7:0] d, input logic lsb_first);
    usp_pick = lsb_first ? d[0] : d[7];
  endfunction

  // Moves the shifter one place toward the wire end
  function automatic logic [7:0] usp_step(input logic [7:0] d, input logic lsb_first,
                                          input logic in_bit);
    usp_step = lsb_first ? {in_bit, d[7:1]} : {d[6:0], in_bit};
  endfunction

  // ****************************************************************
  // Submodules
  // ****************************************************************
  usp_pin_sync u_miso_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async (i_miso),
    .o_level (miso_level)
  );

  usp_baud_gen #(
    .W (DIV_W)
  ) u_baud (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_run     (state == ST_SHIFT),
    .i_reload  (i_wr && i_addr == USP_OFS_BAUD_LO),
    .i_divisor (divider),
    .o_tick    (tick)
  );

  // ****************************************************************
  // Decode and transfer control
  // ****************************************************************
  always_comb begin
    spi_mode    = ctrl_c.mode == USP_MODE_SPI;
    tx_en       = spi_mode && ctrl_b[USP_B_TXEN];
    rx_en       = tx_en && ctrl_b[USP_B_RXEN];
    wr_data     = i_wr && i_addr == USP_OFS_DATA;
    rd_data     = i_rd && i_addr == USP_OFS_DATA;
    leading     = !edge_cnt[0];
    sample_edge = tick && (frame.cpha ? !leading : leading);
    setup_edge  = tick && (frame.cpha ? leading : !leading);
    frame_done  = state == ST_SHIFT && tick && edge_cnt == USP_LAST_EDGE;
    // Pending byte goes out even after the enable drops
    load        = tx_buf_valid && (state == ST_IDLE || frame_done);
    next_rx     = sample_edge ? usp_step(rx_shift, frame.lsb_first, miso_level) : rx_shift;
    next_tx     = usp_step(tx_shift, frame.lsb_first, 1'b1);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (load) begin
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (frame_done && !load) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Settings are taken per frame so a late write cannot split a byte
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      frame <= '0;
    end else if (load) begin
      frame <= {ctrl_c.lsb_first, ctrl_c.cpha, ctrl_c.cpol};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      edge_cnt <= USP_FIRST_EDGE;
    end else if (load) begin
      edge_cnt <= USP_FIRST_EDGE;
    end else if (state == ST_SHIFT && tick) begin
      edge_cnt <= edge_cnt + 1'b1;
    end
  end

  // ****************************************************************
  // Shifters and serial pins
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tx_shift <= 8'hff;
      o_mosi   <= 1'b1;
    end else if (load) begin
      tx_shift <= tx_buf;
      // Phase one keeps the last bit past its closing sample edge
      o_mosi   <= ctrl_c.cpha ? o_mosi : usp_pick(tx_buf, ctrl_c.lsb_first);
    end else if (setup_edge && edge_cnt == USP_FIRST_EDGE) begin
      o_mosi   <= usp_pick(tx_shift, frame.lsb_first);
    end else if (setup_edge) begin
      tx_shift <= next_tx;
      o_mosi   <= usp_pick(next_tx, frame.lsb_first);
    end else if (state == ST_IDLE) begin
      o_mosi   <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rx_shift <= 8'h00;
    end else begin
      rx_shift <= next_rx;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_sclk <= 1'b0;
    end else if (state == ST_SHIFT && tick) begin
      o_sclk <= !o_sclk;
    end else if (state == ST_IDLE) begin
      o_sclk <= ctrl_c.cpol;
    end
  end

  // Pins stay taken while anything is still queued
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_mosi_oe <= 1'b0;
      o_sclk_oe <= 1'b0;
    end else begin
      o_mosi_oe <= tx_en || state == ST_SHIFT || tx_buf_valid;
      o_sclk_oe <= tx_en || state == ST_SHIFT || tx_buf_valid;
    end
  end

  // ****************************************************************
  // Buffers
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tx_buf       <= 8'h00;
      tx_buf_valid <= 1'b0;
    end else if (wr_data && tx_en && !tx_buf_valid) begin
      tx_buf       <= i_wdata;
      tx_buf_valid <= 1'b1;
    end else if (load) begin
      tx_buf_valid <= 1'b0;
    end
  end

  // Full buffer keeps the old byte; the newest one is lost
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rx_buf       <= 8'h00;
      rx_buf_valid <= 1'b0;
    end else if (!rx_en) begin
      rx_buf_valid <= 1'b0;
    end else if (frame_done && !rx_buf_valid) begin
      rx_buf       <= next_rx;
      rx_buf_valid <= 1'b1;
    end else if (rd_data) begin
      rx_buf_valid <= 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_b <= USP_RST_CTRL_B;
      ctrl_c <= USP_RST_CTRL_C;
      mask   <= USP_RST_MASK;
    end else if (i_wr) begin
      case (i_addr)
        USP_OFS_CTRL_B: ctrl_b <= i_wdata;
        USP_OFS_CTRL_C: ctrl_c <= i_wdata;
        USP_OFS_MASK:   mask   <= i_wdata[2:0];
        default:        ctrl_b <= ctrl_b;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      divider <= USP_RST_BAUD;
    end else if (i_wr && i_addr == USP_OFS_BAUD_LO) begin
      divider[7:0] <= i_wdata;
    end else if (i_wr && i_addr == USP_OFS_BAUD_HI) begin
      divider[DIV_W-1:8] <= i_wdata[USP_BAUD_HI_W-1:0];
    end
  end

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  always_comb begin
    ev_set              = '0;
    ev_set[USP_EV_RXC]  = frame_done && rx_en && !rx_buf_valid;
    ev_set[USP_EV_TXC]  = frame_done && !tx_buf_valid;
    ev_set[USP_EV_UDRE] = load;
    ev_clr              = '0;
    if (i_wr && i_addr == USP_OFS_EVENT) begin
      ev_clr = i_wdata[2:0];
    end else if (i_wr && i_addr == USP_OFS_STATUS) begin
      ev_clr[USP_EV_TXC] = i_wdata[USP_ST_TXC];
    end
  end

  // A new event beats a clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      events <= USP_RST_EVENT;
    end else begin
      events <= (events & ~ev_clr) | ev_set;
    end
  end

  // Global enable lives in the core; this is only the block's request
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((events & ~ev_clr) | ev_set) & mask);
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        USP_OFS_STATUS:  o_rdata <= {rx_buf_valid, events[USP_EV_TXC], !tx_buf_valid,
                                     5'h00};
        USP_OFS_CTRL_B:  o_rdata <= ctrl_b;
        USP_OFS_CTRL_C:  o_rdata <= ctrl_c;
        USP_OFS_BAUD_LO: o_rdata <= divider[7:0];
        USP_OFS_BAUD_HI: o_rdata <= {4'h0, divider[DIV_W-1:8]};
        USP_OFS_DATA:    o_rdata <= rx_buf;
        USP_OFS_EVENT:   o_rdata <= {5'h00, events};
        USP_OFS_MASK:    o_rdata <= {5'h00, mask};
        default:         o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// file: tb/usp_props.sv
`timescale 1ns/10ps
`default_nettype none
module usp_props
  import usp_pkg::*;
#(
  parameter int DIV_W = 12
) (
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_irq,
  input wire logic       i_miso,
  input wire logic       o_sclk,
  input wire logic       o_sclk_oe,
  input wire logic       o_mosi,
  input wire logic       o_mosi_oe
);
  // ****************
  // Register shadow
  // ****************
  logic [DIV_W-1:0] div_q;
  logic [1:0]       mode_q;
  logic             txen_q;
  logic [7:0]       gap_q;
  logic             sclk_q;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      div_q  <= '0;
      mode_q <= 2'h0;
      txen_q <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == USP_OFS_BAUD_LO) div_q[7:0] <= i_wdata;
      if (i_addr == USP_OFS_BAUD_HI) div_q[DIV_W-1:8] <= i_wdata[DIV_W-9:0];
      if (i_addr == USP_OFS_CTRL_C) mode_q <= i_wdata[7:6];
      if (i_addr == USP_OFS_CTRL_B) txen_q <= i_wdata[USP_B_TXEN];
    end
  end
  // Saturates, so only edges inside a frame are measured
  always_ff @(posedge i_clock) begin
    sclk_q <= o_sclk;
    if (i_rst || o_sclk != sclk_q) gap_q <= 8'h00;
    else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  chk_half_period: assert property (($changed(o_sclk) && gap_q < 8'h1e) |-> gap_q == div_q)
    else $error("sclk half period wrong");
  chk_baud_hi_rb: assert property ((i_rd && i_addr == USP_OFS_BAUD_HI) |=>
    o_rdata == {4'h0, div_q[DIV_W-1:8]}) else $error("divider high readback wrong");
  chk_status_zero: assert property ((i_rd && i_addr == USP_OFS_STATUS) |=>
    o_rdata[4:0] == 5'h00) else $error("error flags not zero");
  chk_refused_write: assert property ((i_wr && i_addr == USP_OFS_DATA &&
    mode_q != USP_MODE_SPI) |=> (o_mosi && $stable(o_sclk)) [*8])
    else $error("data write outside spi mode acted");
  chk_oe_enable: assert property ((i_wr && i_addr == USP_OFS_CTRL_B &&
    i_wdata[USP_B_TXEN]) |-> ##[1:2] o_sclk_oe) else $error("drive enable missing");
  chk_irq_masked: assert property ((i_wr && i_addr == USP_OFS_MASK &&
    i_wdata[2:0] == 3'h0) |-> ##2 !o_irq) else $error("irq with all masked");
  chk_mosi_idle: assert property (!o_sclk_oe |-> o_mosi)
    else $error("mosi not idle high");
  chk_write_starts: assert property ((i_wr && i_addr == USP_OFS_DATA && txen_q &&
    mode_q == USP_MODE_SPI && div_q < 12'h064 && gap_q > 8'h1e) |-> ##[1:200] $changed(o_sclk))
    else $error("data write started no frame");
  cov_frame_edge: cover property ($changed(o_sclk) && gap_q < 8'h1e);
  cov_irq: cover property ($rose(o_irq));
  cov_oe: cover property ($rose(o_sclk_oe));
endmodule
bind usp_spi_master usp_props #(.DIV_W(DIV_W)) usp_props_i (.i_clock(i_clock), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_irq(o_irq), .i_miso(i_miso), .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe),
  .o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe));
`default_nettype wire

// file: tb/usp_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module usp_slave_model (
  input  wire logic        i_clr,
  input  wire logic        i_sclk,
  input  wire logic        i_mosi,
  input  wire logic        i_cpol,
  input  wire logic        i_cpha,
  input  wire logic        i_lsb,
  input  wire logic [7:0]  i_tx,
  output var  logic        o_miso,
  output var  logic [15:0] o_rx,
  output var  int          o_bits
);
  // ****************
  // Slave shifter
  // ****************
  logic [3:0] s = 4'h0;
  logic [3:0] r = 4'h0;
  int         idx;
  initial o_rx = 16'h0000;
  initial o_bits = 0;
  always @(i_sclk or posedge i_clr) begin
    if (i_clr) begin
      s = 4'h0;
      r = 4'h0;
      o_bits = 0;
    end else begin
      if (i_sclk == (i_cpol ~^ i_cpha)) begin
        o_rx = {o_rx[14:0], i_mosi};
        r = r + 4'h1;
        o_bits = o_bits + 1;
      end else begin
        s = s + 4'h1;
      end
      if (r == 4'h8 && s == 4'h8) begin
        r = 4'h0;
        s = 4'h0;
      end
    end
  end
  // Before the first setup edge of a phase-one frame the line shows junk
  always @* begin
    idx = i_cpha ? int'(s) - 1 : int'(s);
    if (i_cpha && s == 4'h0) o_miso = ~i_tx[i_lsb ? 0 : 7];
    else o_miso = i_tx[i_lsb ? idx[2:0] : 3'h7 - idx[2:0]];
  end
endmodule
`default_nettype wire

// file: tb/test_usp_spi_master.sv
`timescale 1ns/10ps
`default_nettype none
module test_usp_spi_master
  import usp_pkg::*;
;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [7:0]  i_wdata = 8'h00;
  logic [7:0]  o_rdata;
  logic        o_irq, o_sclk, o_sclk_oe, o_mosi, o_mosi_oe, miso;
  logic        cpol = 1'b0, cpha = 1'b0, lsb = 1'b0, clr = 1'b0;
  logic [7:0]  s_tx = 8'h00, d, mi;
  logic [15:0] m_rx;
  int          m_bits;
  int          n_errors = 0;
  int          total_checks = 0;
  usp_spi_master #(.DIV_W(12)) usp_spi_master_i (.i_clock(i_clock), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .i_miso(miso), .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe),
    .o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe));
  usp_slave_model usp_slave_model_i (.i_clr(clr), .i_sclk(o_sclk), .i_mosi(o_mosi),
    .i_cpol(cpol), .i_cpha(cpha), .i_lsb(lsb), .i_tx(s_tx), .o_miso(miso), .o_rx(m_rx),
    .o_bits(m_bits));
  always #20 i_clock = ~i_clock;
  // ****************
  // Bus and checks
  // ****************
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    v = o_rdata;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wait_txc;
    int k;
    for (k = 0; k < 3000; k++) begin
      rd(USP_OFS_STATUS, d);
      if (d[USP_ST_TXC] === 1'b1) break;
    end
    if (k == 3000) begin
      n_errors++;
      test_done();
    end
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7-i];
  endfunction
  // Settings change only while idle; pauses on both sides keep half period checks clean
  task start(input logic [7:0] c);
    {lsb, cpha, cpol} = c[2:0];
    repeat (40) @(posedge i_clock);
    wr(USP_OFS_CTRL_C, c);
    repeat (40) @(posedge i_clock);
    clr <= 1'b1;
    @(posedge i_clock);
    clr <= 1'b0;
    wr(USP_OFS_EVENT, 8'h02);
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(USP_OFS_CTRL_C, d);
    chk(d, USP_RST_CTRL_C);
    rd(USP_OFS_BAUD_LO, d);
    chk(d, 8'h00);
    rd(USP_OFS_BAUD_HI, d);
    chk(d, 8'h00);
    rd(8'hc3, d);
    chk(d, 8'h00);
    wr(USP_OFS_DATA, 8'h55);
    rd(USP_OFS_STATUS, d);
    chk(d, 8'h20);
    chk(o_mosi_oe, 1'b0);
    wr(USP_OFS_BAUD_HI, 8'hff);
    rd(USP_OFS_BAUD_HI, d);
    chk(d, 8'h0f);
    wr(USP_OFS_BAUD_HI, 8'h00);
    $display("test reset done");
    wr(USP_OFS_CTRL_C, 8'hc0);
    wr(USP_OFS_CTRL_B, 8'h18);
    wr(USP_OFS_BAUD_LO, 8'h04);
    wr(USP_OFS_MASK, 8'h02);
    rd(USP_OFS_MASK, d);
    chk(d, 8'h02);
    for (mi = 8'h00; mi < 8'h08; mi++) begin
      start({5'h18, mi[2:0]});
      s_tx = 8'hc3 ^ mi;
      wr(USP_OFS_DATA, 8'h3c ^ mi);
      wait_txc();
      chk(d, 8'he0);
      chk(m_bits[15:0], 16'h0008);
      chk(m_rx[7:0], lsb ? rev(8'h3c ^ mi) : 8'h3c ^ mi);
      chk(o_mosi, 1'b1);
      chk(o_irq, 1'b1);
      chk(o_mosi_oe, 1'b1);
      rd(USP_OFS_EVENT, d);
      chk(d, 8'h07);
      rd(USP_OFS_DATA, d);
      chk(d, s_tx);
    end
    $display("test modes done");
    wr(USP_OFS_MASK, 8'h00);
    wr(USP_OFS_EVENT, 8'h07);
    rd(USP_OFS_EVENT, d);
    chk(d, 8'h00);
    chk(o_irq, 1'b0);
    start(8'hc0);
    wr(USP_OFS_DATA, 8'ha1);
    repeat (3) @(posedge i_clock);
    wr(USP_OFS_DATA, 8'h7e);
    wait_txc();
    chk(m_bits[15:0], 16'h0010);
    chk(m_rx, 16'ha17e);
    rd(USP_OFS_DATA, d);
    chk(d, s_tx);
    $display("test double byte done");
    wr(USP_OFS_CTRL_B, 8'h08);
    start(8'hc4);
    wr(USP_OFS_DATA, 8'h96);
    wait_txc();
    chk(m_rx[7:0], rev(8'h96));
    rd(USP_OFS_STATUS, d);
    chk(d[USP_ST_RXC], 1'b0);
    $display("test transmit only done");
    test_done();
  end
endmodule
`default_nettype wire
